// ---- tocr_consts.svh ----
`ifndef TOCR_CONSTS_SVH
`define TOCR_CONSTS_SVH
// Register map, byte addresses
`define TOCR_ADDR_OPT 12'h008
`define TOCR_ADDR_STAT 12'h00c
`define TOCR_OPT_RESET 16'h0000
// Option register fields
`define TOCR_B_EXT_TEST 15
`define TOCR_B_INHIBIT_TEST 14
`define TOCR_B_VEC_OVR 13
`define TOCR_B_WIDE_CW 12
`define TOCR_B_BCAST_MASK 11
`define TOCR_B_RETRY_LEGACY 10
`define TOCR_B_RETRY_SSET 9
`define TOCR_B_RETRY1_BUS 8
`define TOCR_B_RETRY2_BUS 7
// Mode codes
`define TOCR_MC_TX_TEST 5'h13
`define TOCR_MC_TX_VEC 5'h10
`define TOCR_MC_RSV_LO 5'h16
`define TOCR_TEST_FIXED_ADDR 16'h0123
// Controller control word
`define TOCR_CW_LEGACY_MASK 16'h00e7
`define TOCR_CW_WIDE_MASK 16'h7fff
`define TOCR_CW_BCAST 5
`define TOCR_CW_LEGACY 3
// Returned status word
`define TOCR_SW_CHECKED 16'h070f
`define TOCR_SW_BCAST 4
`define TOCR_SW_MSGERR 10
`endif

// ---- tocr_pkg.sv ----
package tocr_pkg;
  typedef logic [15:0] tocr_word_t;
  typedef enum logic [2:0] {
    TOCR_SRC_NONE = 3'b001,
    TOCR_SRC_INTERNAL = 3'b010,
    TOCR_SRC_RAM = 3'b100
  } tocr_src_e;
endpackage

// ---- tocr_opt_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface tocr_opt_if;
  import tocr_pkg::*;
  // Option bits already gated by enhanced operation
  tocr_word_t eff;
  modport src (output eff);
  modport dst (input eff);
endinterface
`default_nettype wire

// ---- tocr_rt_reply.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tocr_consts.svh"
module tocr_rt_reply
  import tocr_pkg::*;
(
  tocr_opt_if.dst opt,
  input wire logic tx,
  input wire logic [4:0] mode_code,
  input wire logic per_modecode_handling,
  input wire logic host_busy_n,
  input wire logic busy_table_enable,
  input wire logic busy_table_bit,
  input wire logic [15:0] lut_ptr,
  output logic busy,
  output logic handled,
  output logic send_data,
  output tocr_src_e src,
  output logic [15:0] ram_addr
);
  logic is_test;
  logic is_vec;

  always_comb begin
    busy = ~host_busy_n | (busy_table_enable & busy_table_bit); // RL5
    is_test = tx && (mode_code == `TOCR_MC_TX_TEST);
    is_vec = tx && (mode_code == `TOCR_MC_TX_VEC ||
      mode_code >= `TOCR_MC_RSV_LO);
    handled = is_test | is_vec;
    send_data = 1'b0;
    src = TOCR_SRC_NONE;
    ram_addr = lut_ptr;
    if (is_test) begin
      send_data = ~(busy & opt.eff[`TOCR_B_INHIBIT_TEST]); // RL6 RL7
      if (opt.eff[`TOCR_B_EXT_TEST]) begin
        src = TOCR_SRC_RAM; // RL2
        if (per_modecode_handling) begin
          ram_addr = `TOCR_TEST_FIXED_ADDR; // RL4
        end
      end else begin
        src = TOCR_SRC_INTERNAL; // RL2
      end
    end else if (is_vec) begin
      send_data = ~(busy & ~opt.eff[`TOCR_B_VEC_OVR]); // RL8 RL9
      src = TOCR_SRC_RAM; // RL3
    end
    if (!send_data) begin
      src = TOCR_SRC_NONE;
    end
  end
endmodule // tocr_rt_reply
`default_nettype wire

// ---- tocr_bc_eval.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tocr_consts.svh"
module tocr_bc_eval
  import tocr_pkg::*;
(
  tocr_opt_if.dst opt,
  input wire logic [15:0] ctrl_word,
  input wire logic [15:0] status_word,
  input wire logic no_response,
  input wire logic format_error,
  input wire logic [1:0] attempt,
  output logic [15:0] ctrl_eff,
  output logic status_set,
  output logic retry,
  output logic retry_alt_bus
);
  logic [15:0] mask;
  logic bcast_hit;
  logic legacy_err;

  always_comb begin
    ctrl_eff = ctrl_word & (opt.eff[`TOCR_B_WIDE_CW] ?
      `TOCR_CW_WIDE_MASK : `TOCR_CW_LEGACY_MASK); // RL10
    // Mask bits are zero unless the wide word is active
    mask = {5'h00, ctrl_eff[14:12], 4'h0, ctrl_eff[11:8]}; // RL18
    if (opt.eff[`TOCR_B_BCAST_MASK]) begin
      bcast_hit = ~ctrl_eff[`TOCR_CW_BCAST] &
        status_word[`TOCR_SW_BCAST]; // RL12
    end else begin
      bcast_hit = ctrl_eff[`TOCR_CW_BCAST] ^
        status_word[`TOCR_SW_BCAST]; // RL11
    end
    status_set = |(status_word & `TOCR_SW_CHECKED & ~mask) |
      bcast_hit; // RL17
    legacy_err = opt.eff[`TOCR_B_RETRY_LEGACY] &
      ctrl_eff[`TOCR_CW_LEGACY] & status_word[`TOCR_SW_MSGERR]; // RL14
    retry = no_response | format_error | legacy_err | // RL13
      (opt.eff[`TOCR_B_RETRY_SSET] & status_set); // RL15 RL16
    retry_alt_bus = (attempt == 2'h0) ? opt.eff[`TOCR_B_RETRY1_BUS] :
      opt.eff[`TOCR_B_RETRY2_BUS]; // RL19
  end
endmodule // tocr_bc_eval
`default_nettype wire

// ---- tocr_top.sv ----
// Overview of operation
// RL1 - All option functions need enhanced operation enabled first.
// RL2 - Test word comes from internal register, or shared RAM when bit 15 set.
// RL3 - External test word without per-mode-code handling uses lookup pointer.
// RL4 - External test word with per-mode-code handling reads fixed address 0123.
// RL5 - Busy when host busy is low or busy table enabled with bit set.
// RL6 - Bit 14 clear and busy: busy status then test word.
// RL7 - Bit 14 set and busy: busy status and no data word.
// RL8 - Bit 13 clear and busy: vector or reserved codes get status only.
// RL9 - Bit 13 set and busy: vector or reserved codes get one data word.
// RL10 - Controller word limited to bits 7,6,5,2,1,0 unless wide enabled.
// RL11 - Bit 11 clear: broadcast mask flips expected broadcast status to one.
// RL12 - Bit 11 set: broadcast bit counts only when mask bit is zero.
// RL13 - Bit 10 clear: retry only on timeout or format errors.
// RL14 - Bit 10 set: also retry on legacy select with message error.
// RL15 - Bit 9 clear: set status bits cause no retry, bar legacy case.
// RL16 - Bit 9 set: retry any message with a status-set condition.
// RL17 - Bit 12 clear: all eight non-reserved status bits are checked.
// RL18 - Wide word: only status bits with zero mask bits count.
// RL19 - Bit 8 picks first retry bus, bit 7 second; one is alternate.
// RL20 - Host keeps the three low test-mode bits at zero.
// RL21 - All sixteen bits are stored on write and read back.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tocr_consts.svh"
module tocr_top
  import tocr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enhanced_enable,
  input wire logic per_modecode_handling,
  input wire logic host_busy_n,
  input wire logic busy_table_enable,
  input wire logic busy_table_bit,
  input wire logic rt_req,
  input wire logic rt_tx,
  input wire logic [4:0] rt_mode_code,
  input wire logic [15:0] rt_lut_ptr,
  output logic rt_ack,
  output logic rt_busy,
  output logic rt_handled,
  output logic rt_send_data,
  output logic rt_data_from_ram,
  output logic rt_data_internal,
  output logic [15:0] rt_data_addr,
  input wire logic bc_req,
  input wire logic [15:0] bc_ctrl_word,
  input wire logic [15:0] bc_status_word,
  input wire logic bc_no_response,
  input wire logic bc_format_error,
  input wire logic [1:0] bc_attempt,
  output logic bc_ack,
  output logic [15:0] bc_ctrl_eff,
  output logic bc_status_set,
  output logic bc_retry,
  output logic bc_retry_alt_bus
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  tocr_word_t opt_r;
  logic [7:0] retry_cnt_r;
  logic [7:0] retry_cnt_nxt;
  logic [31:0] rdata_nxt;
  logic hit_opt;
  logic hit_stat;
  logic access;
  logic commit;
  logic [15:0] stat_word;
  logic w_busy;
  logic w_handled;
  logic w_send;
  tocr_src_e w_src;
  logic [15:0] w_addr;
  logic [15:0] w_ctrl_eff;
  logic w_sset;
  logic w_retry;
  logic w_alt;

  tocr_opt_if opt_bus ();

  //////////////////////////////////////////////////////////////////////////
  // Option gating

  // Stored bits stay readable; they only act in enhanced operation
  assign opt_bus.eff = enhanced_enable ? opt_r : 16'h0000; // RL1

  //////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state

  assign hit_opt = (paddr == `TOCR_ADDR_OPT);
  assign hit_stat = (paddr == `TOCR_ADDR_STAT);
  assign access = psel & penable;
  assign commit = access & pready;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pslverr <= ~(hit_opt | (hit_stat & ~pwrite));
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_opt) begin
      rdata_nxt = {16'h0000, opt_r}; // RL21
    end else if (hit_stat) begin
      rdata_nxt = {16'h0000, stat_word};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pready && !pwrite) begin
      prdata <= rdata_nxt;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Option register

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      opt_r <= `TOCR_OPT_RESET;
    end else if (commit && pwrite && hit_opt) begin
      if (pstrb[0]) begin
        opt_r[7:0] <= pwdata[7:0]; // RL21
      end
      if (pstrb[1]) begin
        opt_r[15:8] <= pwdata[15:8]; // RL21
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status word

  assign stat_word = {retry_cnt_r, 1'b0, opt_bus.eff[`TOCR_B_WIDE_CW],
    enhanced_enable, bc_retry_alt_bus, bc_retry, bc_status_set,
    rt_send_data, rt_busy};

  always_comb begin
    retry_cnt_nxt = retry_cnt_r;
    if (bc_req && w_retry && retry_cnt_r != 8'hff) begin
      retry_cnt_nxt = retry_cnt_r + 8'h01;
    end
  end

  // Saturating count of retry decisions, cleared by any option write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      retry_cnt_r <= 8'h00;
    end else if (commit && pwrite && hit_opt) begin
      retry_cnt_r <= 8'h00;
    end else begin
      retry_cnt_r <= retry_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Remote terminal reply decision

  tocr_rt_reply u_rt (
    .opt(opt_bus),
    .tx(rt_tx),
    .mode_code(rt_mode_code),
    .per_modecode_handling(per_modecode_handling),
    .host_busy_n(host_busy_n),
    .busy_table_enable(busy_table_enable),
    .busy_table_bit(busy_table_bit),
    .lut_ptr(rt_lut_ptr),
    .busy(w_busy),
    .handled(w_handled),
    .send_data(w_send),
    .src(w_src),
    .ram_addr(w_addr)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rt_ack <= 1'b0;
    end else begin
      rt_ack <= rt_req;
    end
  end

  // Answer held until the next request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rt_busy <= 1'b0;
      rt_handled <= 1'b0;
      rt_send_data <= 1'b0;
      rt_data_from_ram <= 1'b0;
      rt_data_internal <= 1'b0;
      rt_data_addr <= 16'h0000;
    end else if (rt_req) begin
      rt_busy <= w_busy; // RL5
      rt_handled <= w_handled;
      rt_send_data <= w_send; // RL7 RL9
      rt_data_from_ram <= (w_src == TOCR_SRC_RAM); // RL2
      rt_data_internal <= (w_src == TOCR_SRC_INTERNAL); // RL2
      rt_data_addr <= (w_src == TOCR_SRC_RAM) ? w_addr : 16'h0000; // RL3
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus controller evaluation

  tocr_bc_eval u_bc (
    .opt(opt_bus),
    .ctrl_word(bc_ctrl_word),
    .status_word(bc_status_word),
    .no_response(bc_no_response),
    .format_error(bc_format_error),
    .attempt(bc_attempt),
    .ctrl_eff(w_ctrl_eff),
    .status_set(w_sset),
    .retry(w_retry),
    .retry_alt_bus(w_alt)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bc_ack <= 1'b0;
    end else begin
      bc_ack <= bc_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bc_ctrl_eff <= 16'h0000;
      bc_status_set <= 1'b0;
      bc_retry <= 1'b0;
      bc_retry_alt_bus <= 1'b0;
    end else if (bc_req) begin
      bc_ctrl_eff <= w_ctrl_eff; // RL10
      bc_status_set <= w_sset; // RL17
      bc_retry <= w_retry; // RL16
      bc_retry_alt_bus <= w_alt; // RL19
    end
  end

endmodule // tocr_top
`default_nettype wire

// ---- tocr_top_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module tocr_top_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic enhanced_enable,
  input wire logic host_busy_n,
  input wire logic rt_req,
  input wire logic rt_tx,
  input wire logic [4:0] rt_mode_code,
  input wire logic rt_ack,
  input wire logic rt_busy,
  input wire logic rt_data_internal,
  input wire logic bc_req,
  input wire logic [15:0] bc_ctrl_word,
  input wire logic bc_no_response,
  input wire logic bc_ack,
  input wire logic [15:0] bc_ctrl_eff,
  input wire logic bc_retry
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_apb_one_wait: assert property (
    psel && !penable |=> !pready ##1 pready) else $error("pready late");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("pready held");
  a_rt_ack: assert property (
    rt_req |=> rt_ack) else $error("rt_ack missing");
  a_bc_ack: assert property (
    bc_req |=> bc_ack) else $error("bc_ack missing");
  a_host_busy: assert property (
    rt_req && !host_busy_n |=> rt_busy) else $error("busy missed");
  a_cw_narrow: assert property (
    bc_req && !enhanced_enable |=>
    bc_ctrl_eff == ($past(bc_ctrl_word) & 16'h00e7)) else $error("cw wide");
  a_retry_timeout: assert property (
    bc_req && bc_no_response |=> bc_retry) else $error("no retry");
  a_test_internal: assert property (
    rt_req && rt_tx && rt_mode_code == 5'h13 && !enhanced_enable |=>
    rt_data_internal) else $error("test word source");
  c_retry: cover property (bc_ack && bc_retry);
  c_busy: cover property (rt_ack && rt_busy);
  c_apb: cover property (psel && pready);
endmodule // tocr_top_asserts
bind tocr_top tocr_top_asserts u_chk (.*);
`default_nettype wire

// ---- tocr_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module tocr_bus_model (
  input wire logic clk_sys,
  output logic rt_req = 1'b0,
  output logic rt_tx = 1'b0,
  output logic [4:0] rt_mode_code = 5'h00,
  output logic [15:0] rt_lut_ptr = 16'h0000,
  output logic bc_req = 1'b0,
  output logic [15:0] bc_ctrl_word = 16'h0000,
  output logic [15:0] bc_status_word = 16'h0000,
  output logic bc_no_response = 1'b0,
  output logic bc_format_error = 1'b0,
  output logic [1:0] bc_attempt = 2'h0
);
  // Fields go to the inverse once the request is gone; the bc error flags keep their value
  task automatic rt(input logic [4:0] c, input logic [15:0] p);
    @(posedge clk_sys);
    rt_req <= 1'b1;
    rt_tx <= 1'b1;
    rt_mode_code <= c;
    rt_lut_ptr <= p;
    @(posedge clk_sys);
    rt_req <= 1'b0;
    rt_tx <= 1'b0;
    rt_mode_code <= ~c;
    rt_lut_ptr <= ~p;
    #1;
  endtask
  task automatic bc(input logic [15:0] cw, input logic [15:0] sw,
    input logic [1:0] er, input logic [1:0] at);
    @(posedge clk_sys);
    bc_req <= 1'b1;
    bc_ctrl_word <= cw;
    bc_status_word <= sw;
    {bc_no_response, bc_format_error} <= er;
    bc_attempt <= at;
    @(posedge clk_sys);
    bc_req <= 1'b0;
    bc_ctrl_word <= ~cw;
    bc_status_word <= ~sw;
    bc_attempt <= ~at;
    #1;
  endtask
endmodule // tocr_bus_model
`default_nettype wire

// ---- tocr_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tocr_top_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, rt_req, rt_tx, rt_ack, rt_busy, rt_handled;
  logic enhanced_enable = 1'b0, per_modecode_handling = 1'b0;
  logic host_busy_n = 1'b1, busy_table_enable = 1'b0, busy_table_bit = 1'b0;
  logic rt_send_data, rt_data_from_ram, rt_data_internal, bc_req, bc_ack;
  logic bc_no_response, bc_format_error, bc_status_set, bc_retry;
  logic bc_retry_alt_bus;
  logic [4:0] rt_mode_code;
  logic [15:0] rt_lut_ptr, rt_data_addr, bc_ctrl_word, bc_status_word;
  logic [15:0] bc_ctrl_eff;
  logic [1:0] bc_attempt;
  localparam logic [18:0] X_INT = 19'h50000;
  localparam logic [18:0] X_PTR = 19'h60240;
  localparam logic [18:0] X_FIX = 19'h60123;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  tocr_top dut (.*);
  tocr_bus_model m (.*);
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer; error flag packed above the read data
  task automatic rio(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e);
    int t;
    t = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 50);
    chk("apb", e, {pslverr, prdata});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic opt(input logic [15:0] v);
    rio(1'b1, 12'h008, {16'h0, v}, '0);
  endtask
  task automatic rtc(input logic [4:0] c, input logic [18:0] e);
    m.rt(c, 16'h0240);
    chk("rt", e, {rt_send_data, rt_data_from_ram, rt_data_internal,
      rt_data_addr});
    chk("handled", 40'(c == 5'h13 || c == 5'h10 || c >= 5'h16),
      40'(rt_handled));
  endtask
  task automatic bcc(input logic [15:0] cw, input logic [15:0] sw,
    input logic [1:0] er, input logic [1:0] at, input logic [18:0] e);
    m.bc(cw, sw, er, at);
    chk("bc", e, {bc_ctrl_eff, bc_status_set, bc_retry, bc_retry_alt_bus});
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rio(1'b0, 12'h008, '0, '0);
    rio(1'b1, 12'h008, 32'h1234a5c3, '0);
    rio(1'b0, 12'h008, '0, 33'h00000a5c3);
    rio(1'b0, 12'h040, '0, 33'h100000000);
    enhanced_enable <= 1'b1;
    opt(16'h8000);
    rtc(5'h13, X_PTR);
    per_modecode_handling <= 1'b1;
    rtc(5'h13, X_FIX);
    opt(16'h0000);
    rtc(5'h13, X_INT);
    host_busy_n <= 1'b0;
    rtc(5'h13, X_INT);
    opt(16'h4000);
    rtc(5'h13, '0);
    for (int v = 0; v < 2; v++) begin
      opt(v ? 16'h2000 : 16'h0000);
      for (int c = 21; c < 32; c++) begin
        rtc(c == 21 ? 5'h10 : 5'(c), v ? X_PTR : '0);
      end
    end
    rtc(5'h01, '0);
    host_busy_n <= 1'b1;
    busy_table_enable <= 1'b1;
    busy_table_bit <= 1'b1;
    opt(16'h4000);
    rtc(5'h13, '0);
    busy_table_bit <= 1'b0;
    rtc(5'h13, X_INT);
    enhanced_enable <= 1'b0;
    busy_table_bit <= 1'b1;
    rtc(5'h13, X_INT);
    enhanced_enable <= 1'b1;
    opt(16'h0000);
    bcc(16'hffff, 16'h0000, 2'b00, 2'd0, {16'h00e7, 3'b100});
    bcc(16'h0000, 16'h0000, 2'b10, 2'd0, {16'h0, 3'b010});
    bcc(16'h0000, 16'h0000, 2'b01, 2'd0, {16'h0, 3'b010});
    bcc(16'h0000, 16'h0001, 2'b00, 2'd0, {16'h0, 3'b100});
    opt(16'h0200);
    bcc(16'h0000, 16'h0001, 2'b00, 2'd0, {16'h0, 3'b110});
    opt(16'h0a00);
    bcc(16'h0000, 16'h0010, 2'b00, 2'd0, {16'h0, 3'b110});
    bcc(16'h0020, 16'h0010, 2'b00, 2'd0, {16'h0020, 3'b000});
    opt(16'h1000);
    bcc(16'hffff, 16'h0411, 2'b00, 2'd0, {16'h7fff, 3'b000});
    bcc(16'h0108, 16'h0401, 2'b00, 2'd0, {16'h0108, 3'b100});
    opt(16'h1400);
    bcc(16'h0108, 16'h0401, 2'b00, 2'd0, {16'h0108, 3'b110});
    opt(16'h0100);
    bcc(16'h0000, 16'h0000, 2'b10, 2'd0, {16'h0, 3'b011});
    bcc(16'h0000, 16'h0000, 2'b10, 2'd1, {16'h0, 3'b010});
    opt(16'h0080);
    bcc(16'h0000, 16'h0000, 2'b10, 2'd1, {16'h0, 3'b011});
    enhanced_enable <= 1'b0;
    opt(16'h1a00);
    bcc(16'hffff, 16'h0001, 2'b00, 2'd0, {16'h00e7, 3'b100});
    rio(1'b0, 12'h00c, '0, 33'h000000007);
    rio(1'b1, 12'h00c, 32'h0000ffff, 33'h100000000);
    report_and_stop();
  end
endmodule // tocr_top_tb
`default_nettype wire
